/* File: core/nibble_port_params.svh */
`ifndef NIBBLE_PORT_PARAMS_SVH
`define NIBBLE_PORT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_PORT_A_OUTPUT_LATCH 4'h0
`define IDX_PORT_A_PULL_UP_CTRL 4'h1
`define IDX_PORT_A_OPEN_DRAIN_CTRL 4'h2
`define IDX_PORT_A_DIRECTION 4'h3
`define IDX_PORT_A_STOP_RELEASE 4'h4
`define IDX_PORT_A_FUNCTION_SELECT_LOW 4'h5
`define IDX_PORT_A_FUNCTION_SELECT_HIGH 4'h6
`define IDX_PORT_A_DRIVE_STRENGTH 4'h7
`define IDX_PORT_B_OUTPUT_LATCH 4'h8
`define IDX_PORT_B_PULL_UP_CTRL 4'h9
`define IDX_PORT_B_OPEN_DRAIN_CTRL 4'ha
`define IDX_PORT_B_DIRECTION 4'hb
`define IDX_PORT_B_STOP_RELEASE 4'hc
`define IDX_PORT_B_FUNCTION_SELECT_LOW 4'hd
`define IDX_PORT_B_FUNCTION_SELECT_HIGH 4'he
`define IDX_PORT_B_DRIVE_STRENGTH 4'hf

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_OUTPUT_LATCH 4'hf
`define RST_PULL_UP_CTRL 4'hf
`define RST_OPEN_DRAIN_CTRL 4'hf
`define RST_DIRECTION 4'h0
`define RST_STOP_RELEASE 4'hf
`define RST_FUNCTION_SELECT 4'h0
`define RST_DRIVE_STRENGTH 4'h0

// ----------------------------------------------------------------------------
// Function select codes and AXI responses
// ----------------------------------------------------------------------------
`define FSEL_IO 2'h0
`define FSEL_ANALOG 2'h1
`define FSEL_IRQ 2'h2
`define FSEL_ALT 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: core/nibble_port_pkg.sv */
package nibble_port_pkg;
  // One 4-bit peripheral register or one port's pin vector
  typedef logic [3:0] nibble_t;
  // AXI response code
  typedef logic [1:0] resp_t;
endpackage

/* File: core/dual_nibble_port.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "nibble_port_params.svh"

// Operation
// - Output-direction pin drives the value written into its data latch.
// - Data read returns pin level for inputs, latch value for outputs.
// - Both data latches reset to all ones.
// - Pull-up bit 0 enables the input pull-up, 1 disables it.
// - Pull-up is forced off whenever the pin is an output.
// - Pull-up registers are write-only, reset to all ones.
// - Open-drain bit 0 gives open-drain output, 1 gives push-pull.
// - Open-drain registers are write-only, reset to all ones.
// - Direction bit 0 input, 1 output; readable, writable, reset zero.
// - Stop-release bit 0 allows pin wake from stop; write-only, reset ones.
// - A0 function: io, analog zero, irq/event zero, first timer output.
// - A1 function: io, analog one, irq/event one, converter reference input.
// - A2 function: io, analog two, alternate irq/event zero, pulse zero output.
// - B1 function: io for codes 00 to 10, pulse zero output for 11.
// - B3 function: io, analog seven, pull-down, second timer output.
// - B2 function: io, analog six, pull-down, pulse one output.
// - Drive-strength bit 1 raises output current; write-only, reset zero.
// - B1 only drives low or floats, never drives high.
module dual_nibble_port #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output nibble_port_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output nibble_port_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port A pads, bits 0..2 bonded
  input wire nibble_port_pkg::nibble_t port_a_pad_in,
  output nibble_port_pkg::nibble_t port_a_pad_out,
  output nibble_port_pkg::nibble_t port_a_pad_oe,
  output nibble_port_pkg::nibble_t port_a_pull_up_en,
  output nibble_port_pkg::nibble_t port_a_drive_strong,
  output nibble_port_pkg::nibble_t port_a_wake_en,
  // Port B pads, bits 1..3 bonded
  input wire nibble_port_pkg::nibble_t port_b_pad_in,
  output nibble_port_pkg::nibble_t port_b_pad_out,
  output nibble_port_pkg::nibble_t port_b_pad_oe,
  output nibble_port_pkg::nibble_t port_b_pull_up_en,
  output nibble_port_pkg::nibble_t port_b_pull_down_en,
  output nibble_port_pkg::nibble_t port_b_drive_strong,
  output nibble_port_pkg::nibble_t port_b_wake_en,
  // Analog switch enables toward the converter
  output logic analog_channel_zero,
  output logic analog_channel_one,
  output logic analog_channel_two,
  output logic analog_channel_six,
  output logic analog_channel_seven,
  output logic reference_in_sel,
  // Interrupt and event inputs toward timers and interrupt logic
  output logic external_irq_zero,
  output logic external_irq_one,
  output logic event_count_in_zero,
  output logic event_count_in_one,
  // Timer and pulse outputs from the timers, same clock
  input wire logic timer_out_first,
  input wire logic timer_out_second,
  input wire logic pulse_out_zero,
  input wire logic pulse_out_one
);
  import nibble_port_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  nibble_t port_a_output_latch;
  nibble_t port_a_pull_up_ctrl;
  nibble_t port_a_open_drain_ctrl;
  nibble_t port_a_direction;
  nibble_t port_a_stop_release;
  nibble_t port_a_function_select_low;
  nibble_t port_a_function_select_high;
  nibble_t port_a_drive_strength;
  nibble_t port_b_output_latch;
  nibble_t port_b_pull_up_ctrl;
  nibble_t port_b_open_drain_ctrl;
  nibble_t port_b_direction;
  nibble_t port_b_stop_release;
  nibble_t port_b_function_select_low;
  nibble_t port_b_function_select_high;
  nibble_t port_b_drive_strength;

  // Bus state
  logic aw_held;
  logic w_held;
  logic [3:0] aw_index;
  logic aw_bad;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;

  // Pin synchronisers and pad helpers
  nibble_t a_sync1;
  nibble_t a_sync2;
  nibble_t b_sync1;
  nibble_t b_sync2;
  logic [1:0] a0_fn;
  logic [1:0] a1_fn;
  logic [1:0] a2_fn;
  logic [1:0] b1_fn;
  logic [1:0] b2_fn;
  logic [1:0] b3_fn;
  nibble_t a_fn_out;
  nibble_t a_fn_lvl;
  nibble_t a_analog;
  nibble_t b_fn_out;
  nibble_t b_fn_lvl;
  nibble_t b_analog;
  nibble_t b_od_only;
  nibble_t next_a_read;
  nibble_t next_b_read;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  // Address and data are caught independently so either may come first
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Capture write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 4'h0;
      aw_bad <= 1'b0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[5:2];
      aw_bad <= |(s_axi_awaddr >> 6);
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Capture write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_bad ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Only the low byte lane carries the nibble, so wstrb[0] gates the update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_output_latch <= `RST_OUTPUT_LATCH;
      port_a_pull_up_ctrl <= `RST_PULL_UP_CTRL;
      port_a_open_drain_ctrl <= `RST_OPEN_DRAIN_CTRL;
      port_a_direction <= `RST_DIRECTION;
      port_a_stop_release <= `RST_STOP_RELEASE;
      port_a_function_select_low <= `RST_FUNCTION_SELECT;
      port_a_function_select_high <= `RST_FUNCTION_SELECT;
      port_a_drive_strength <= `RST_DRIVE_STRENGTH;
      port_b_output_latch <= `RST_OUTPUT_LATCH;
      port_b_pull_up_ctrl <= `RST_PULL_UP_CTRL;
      port_b_open_drain_ctrl <= `RST_OPEN_DRAIN_CTRL;
      port_b_direction <= `RST_DIRECTION;
      port_b_stop_release <= `RST_STOP_RELEASE;
      port_b_function_select_low <= `RST_FUNCTION_SELECT;
      port_b_function_select_high <= `RST_FUNCTION_SELECT;
      port_b_drive_strength <= `RST_DRIVE_STRENGTH;
    end else if (wr_fire && !aw_bad && w_strb[0]) begin
      // Latch writes land regardless of direction
      unique case (aw_index)
        `IDX_PORT_A_OUTPUT_LATCH: port_a_output_latch <= w_data[3:0];
        `IDX_PORT_A_PULL_UP_CTRL: port_a_pull_up_ctrl <= w_data[3:0];
        `IDX_PORT_A_OPEN_DRAIN_CTRL: port_a_open_drain_ctrl <= w_data[3:0];
        `IDX_PORT_A_DIRECTION: port_a_direction <= w_data[3:0];
        `IDX_PORT_A_STOP_RELEASE: port_a_stop_release <= w_data[3:0];
        `IDX_PORT_A_FUNCTION_SELECT_LOW: port_a_function_select_low <= w_data[3:0];
        `IDX_PORT_A_FUNCTION_SELECT_HIGH: port_a_function_select_high <= w_data[3:0];
        `IDX_PORT_A_DRIVE_STRENGTH: port_a_drive_strength <= w_data[3:0];
        `IDX_PORT_B_OUTPUT_LATCH: port_b_output_latch <= w_data[3:0];
        `IDX_PORT_B_PULL_UP_CTRL: port_b_pull_up_ctrl <= w_data[3:0];
        `IDX_PORT_B_OPEN_DRAIN_CTRL: port_b_open_drain_ctrl <= w_data[3:0];
        `IDX_PORT_B_DIRECTION: port_b_direction <= w_data[3:0];
        `IDX_PORT_B_STOP_RELEASE: port_b_stop_release <= w_data[3:0];
        `IDX_PORT_B_FUNCTION_SELECT_LOW: port_b_function_select_low <= w_data[3:0];
        `IDX_PORT_B_FUNCTION_SELECT_HIGH: port_b_function_select_high <= w_data[3:0];
        `IDX_PORT_B_DRIVE_STRENGTH: port_b_drive_strength <= w_data[3:0];
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  // Data locations: output bits show the latch, input bits the synced pin
  assign next_a_read = (port_a_direction & port_a_output_latch) | (~port_a_direction & a_sync2);
  assign next_b_read = (port_b_direction & port_b_output_latch) | (~port_b_direction & b_sync2);
  assign s_axi_arready = !s_axi_rvalid;

  // Read answer one cycle after the address; write-only registers read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
      if (|(s_axi_araddr >> 6)) begin
        s_axi_rresp <= `RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr[5:2])
          `IDX_PORT_A_OUTPUT_LATCH: s_axi_rdata[3:0] <= next_a_read;
          `IDX_PORT_A_DIRECTION: s_axi_rdata[3:0] <= port_a_direction;
          `IDX_PORT_A_FUNCTION_SELECT_LOW: s_axi_rdata[3:0] <= port_a_function_select_low;
          `IDX_PORT_A_FUNCTION_SELECT_HIGH: s_axi_rdata[3:0] <= port_a_function_select_high;
          `IDX_PORT_B_OUTPUT_LATCH: s_axi_rdata[3:0] <= next_b_read;
          `IDX_PORT_B_DIRECTION: s_axi_rdata[3:0] <= port_b_direction;
          `IDX_PORT_B_FUNCTION_SELECT_LOW: s_axi_rdata[3:0] <= port_b_function_select_low;
          `IDX_PORT_B_FUNCTION_SELECT_HIGH: s_axi_rdata[3:0] <= port_b_function_select_high;
          default: s_axi_rdata[3:0] <= 4'h0; // Write-only
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Pads are asynchronous to aclk; only the second stage is used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_sync1 <= 4'h0;
      a_sync2 <= 4'h0;
      b_sync1 <= 4'h0;
      b_sync2 <= 4'h0;
    end else begin
      a_sync1 <= port_a_pad_in;
      a_sync2 <= a_sync1;
      b_sync1 <= port_b_pad_in;
      b_sync2 <= b_sync1;
    end
  end

  // --------------------------------------------------------------------------
  // Function selection
  // --------------------------------------------------------------------------
  // Field positions within the selector registers
  assign a0_fn = port_a_function_select_low[1:0];
  assign a1_fn = port_a_function_select_low[3:2];
  assign a2_fn = port_a_function_select_high[1:0];
  assign b1_fn = port_b_function_select_low[3:2];
  assign b2_fn = port_b_function_select_high[1:0];
  assign b3_fn = port_b_function_select_high[3:2];

  // Port A routing
  assign a_analog = {1'b0, a2_fn == `FSEL_ANALOG, a1_fn == `FSEL_ANALOG, a0_fn == `FSEL_ANALOG};
  assign a_fn_out = {1'b0, a2_fn == `FSEL_ALT, 1'b0, a0_fn == `FSEL_ALT};
  assign a_fn_lvl = {1'b0, pulse_out_zero, 1'b0, timer_out_first};
  assign analog_channel_zero = a_analog[0];
  assign analog_channel_one = a_analog[1];
  assign analog_channel_two = a_analog[2];
  // Reference pin: only reference_in_sel rises; the digital driver still follows the direction bit
  assign reference_in_sel = a1_fn == `FSEL_ALT;

  // Interrupt zero may come from A0 or, as alternate, A2; A0 takes priority
  always_comb begin
    external_irq_zero = 1'b0;
    if (a0_fn == `FSEL_IRQ) begin
      external_irq_zero = a_sync2[0];
    end else if (a2_fn == `FSEL_IRQ) begin
      external_irq_zero = a_sync2[2];
    end
  end
  assign event_count_in_zero = external_irq_zero;
  assign external_irq_one = (a1_fn == `FSEL_IRQ) & a_sync2[1];
  assign event_count_in_one = external_irq_one;

  // Port B routing; codes 00 to 10 on B1 are all plain io
  assign b_analog = {b3_fn == `FSEL_ANALOG, b2_fn == `FSEL_ANALOG, 2'b00};
  assign b_fn_out = {b3_fn == `FSEL_ALT, b2_fn == `FSEL_ALT, b1_fn == `FSEL_ALT, 1'b0};
  assign b_fn_lvl = {timer_out_second, pulse_out_one, pulse_out_zero, 1'b0};
  assign analog_channel_six = b_analog[2];
  assign analog_channel_seven = b_analog[3];
  assign port_b_pull_down_en = {b3_fn == `FSEL_IRQ, b2_fn == `FSEL_IRQ, 2'b00};
  // B1 has no high-side driver at all
  assign b_od_only = 4'h2;

  // --------------------------------------------------------------------------
  // Pad control, one slice per bit
  // --------------------------------------------------------------------------
  // A function output drives the pin even while the direction bit says input,
  // so a peripheral can own the pin without software flipping the direction
  for (genvar i = 0; i < 4; i++) begin : g_pad
    logic a_drv;
    logic a_lvl;
    logic a_od;
    logic b_drv;
    logic b_lvl;
    logic b_od;

    // Port A slice
    assign a_drv = (port_a_direction[i] | a_fn_out[i]) & ~a_analog[i];
    assign a_lvl = a_fn_out[i] ? a_fn_lvl[i] : port_a_output_latch[i];
    assign a_od = ~port_a_open_drain_ctrl[i];
    assign port_a_pad_oe[i] = a_drv & (~a_od | ~a_lvl);
    assign port_a_pad_out[i] = a_od ? 1'b0 : a_lvl;
    assign port_a_pull_up_en[i] = ~port_a_pull_up_ctrl[i] & ~(port_a_direction[i] | a_fn_out[i]);
    assign port_a_drive_strong[i] = port_a_drive_strength[i];
    assign port_a_wake_en[i] = ~port_a_stop_release[i];

    // Port B slice
    assign b_drv = (port_b_direction[i] | b_fn_out[i]) & ~b_analog[i];
    assign b_lvl = b_fn_out[i] ? b_fn_lvl[i] : port_b_output_latch[i];
    assign b_od = ~port_b_open_drain_ctrl[i] | b_od_only[i];
    assign port_b_pad_oe[i] = b_drv & (~b_od | ~b_lvl);
    assign port_b_pad_out[i] = b_od ? 1'b0 : b_lvl;
    assign port_b_pull_up_en[i] = ~port_b_pull_up_ctrl[i] & ~(port_b_direction[i] | b_fn_out[i]);
    assign port_b_drive_strong[i] = port_b_drive_strength[i];
    assign port_b_wake_en[i] = ~port_b_stop_release[i];
  end

endmodule

/* File: tb/nibble_pins.sv */
`timescale 1ns/100ps
// ----
// Board and pad model
// ----
module nibble_pins (
  // Clock
  input wire logic aclk,
  // Device side
  input wire nibble_port_pkg::nibble_t pad_out,
  input wire nibble_port_pkg::nibble_t pad_oe,
  input wire nibble_port_pkg::nibble_t pull_up_en,
  input wire nibble_port_pkg::nibble_t pull_down_en,
  // Board side
  input wire nibble_port_pkg::nibble_t ext_en,
  input wire nibble_port_pkg::nibble_t ext_level,
  output nibble_port_pkg::nibble_t pad_level
);
  import nibble_port_pkg::*;
  nibble_t wobble;
  // A floating pin has no level, so it keeps toggling
  always @(posedge aclk) begin
    wobble <= (wobble === 4'h5) ? 4'ha : 4'h5;
  end
  // Device driver wins, then the board, then the pull resistors
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_level)
    | (~pad_oe & ~ext_en & pull_up_en)
    | (~pad_oe & ~ext_en & ~pull_up_en & ~pull_down_en & wobble);
endmodule

/* File: tb/dual_nibble_port_sva.sv */
`timescale 1ns/100ps
// ----
// Pad and bus checker
// ----
module dual_nibble_port_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // Pads and routing
  input wire nibble_port_pkg::nibble_t port_a_pad_oe,
  input wire nibble_port_pkg::nibble_t port_a_pull_up_en,
  input wire nibble_port_pkg::nibble_t port_a_drive_strong,
  input wire nibble_port_pkg::nibble_t port_b_pad_out,
  input wire nibble_port_pkg::nibble_t port_b_pad_oe,
  input wire nibble_port_pkg::nibble_t port_b_pull_up_en,
  input wire nibble_port_pkg::nibble_t port_b_pull_down_en,
  input wire nibble_port_pkg::nibble_t port_b_wake_en,
  input wire logic analog_channel_zero,
  input wire logic analog_channel_seven
);
  import nibble_port_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pull-up must never fight a driven pad
  pu_vs_oe_a: assert property ((port_a_pull_up_en & port_a_pad_oe) == 4'h0)
    else $error("pull-up on while port A pad driven");
  pu_vs_oe_b_a: assert property ((port_b_pull_up_en & port_b_pad_oe) == 4'h0)
    else $error("pull-up on while port B pad driven");
  b1_no_high_a: assert property (port_b_pad_oe[1] |-> !port_b_pad_out[1])
    else $error("port B pin 1 driven high");
  pd_bits_a: assert property (port_b_pull_down_en[1:0] == 2'h0)
    else $error("pull-down on a pin without one");
  analog_off_a: assert property (analog_channel_zero |-> !port_a_pad_oe[0])
    else $error("analog pin A0 still driven");
  seven_off_a: assert property (analog_channel_seven |-> !port_b_pad_oe[3])
    else $error("analog pin B3 still driven");
  reset_state_a: assert property ($rose(aresetn) |-> port_a_pad_oe == 4'h0 && port_b_pad_oe == 4'h0
    && port_a_pull_up_en == 4'h0 && port_b_wake_en == 4'h0 && port_a_drive_strong == 4'h0)
    else $error("pads not in reset state");
  // Config outputs move only when a write lands
  wake_hold_a: assert property ($changed(port_b_wake_en) |-> $rose(s_axi_bvalid))
    else $error("wake enable changed without a write");
  drive_hold_a: assert property ($changed(port_a_drive_strong) |-> $rose(s_axi_bvalid))
    else $error("drive strength changed without a write");
  write_turn_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  read_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:4] == 28'h0) else $error("read answer late or wide");
endmodule
bind dual_nibble_port dual_nibble_port_sva i_dual_nibble_port_sva (.*);

/* File: tb/dual_nibble_port_bench.sv */
`timescale 1ns/100ps
// ----
// Bench
// ----
module dual_nibble_port_bench;
  import nibble_port_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  resp_t s_axi_bresp, s_axi_rresp;
  nibble_t port_a_pad_in, port_a_pad_out, port_a_pad_oe, port_a_pull_up_en, port_a_drive_strong;
  nibble_t port_a_wake_en, port_b_pad_in, port_b_pad_out, port_b_pad_oe, port_b_pull_up_en;
  nibble_t port_b_pull_down_en, port_b_drive_strong, port_b_wake_en, drv_a, drv_b, epd;
  logic analog_channel_zero, analog_channel_one, analog_channel_two, analog_channel_six;
  logic analog_channel_seven, reference_in_sel, external_irq_zero, external_irq_one;
  logic event_count_in_zero, event_count_in_one;
  logic timer_out_first, timer_out_second, pulse_out_zero, pulse_out_one;
  nibble_t m [16];
  nibble_t eoe [2];
  nibble_t eout [2];
  nibble_t epu [2];
  nibble_t epin [2];
  int err_count, total_checks;
  dual_nibble_port i_dual_nibble_port (.*);
  nibble_pins i_pins_a (.aclk(aclk), .pad_out(port_a_pad_out), .pad_oe(port_a_pad_oe),
    .pull_up_en(port_a_pull_up_en), .pull_down_en(4'h0), .ext_en(4'hf), .ext_level(drv_a),
    .pad_level(port_a_pad_in));
  nibble_pins i_pins_b (.aclk(aclk), .pad_out(port_b_pad_out), .pad_oe(port_b_pad_oe),
    .pull_up_en(port_b_pull_up_en), .pull_down_en(port_b_pull_down_en), .ext_en(4'hf),
    .ext_level(drv_b), .pad_level(port_b_pad_in));
  always #2.5 aclk = ~aclk;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Function code of a bonded pin, p*4+i numbering
  function automatic logic [1:0] fc(input int k);
    case (k)
      0: return m[5][1:0];
      1: return m[5][3:2];
      2: return m[6][1:0];
      5: return m[13][3:2];
      6: return m[14][1:0];
      7: return m[14][3:2];
      default: return 2'h0;
    endcase
  endfunction
  // Expected pad state from the register model
  task automatic model_pins();
    logic src, fo, an, od, lv;
    int k;
    for (k = 0; k < 8; k++) begin
      src = k == 0 ? timer_out_first : k == 7 ? timer_out_second : k == 6 ? pulse_out_one : pulse_out_zero;
      fo = fc(k) == 2'h3 && k inside {0, 2, 5, 6, 7};
      an = fc(k) == 2'h1 && k != 5;
      lv = fo ? src : m[k / 4 * 8][k % 4];
      od = !m[k / 4 * 8 + 2][k % 4] || k == 5;
      eoe[k / 4][k % 4] = (fo || m[k / 4 * 8 + 3][k % 4]) && !an && (!od || !lv);
      eout[k / 4][k % 4] = !od && lv;
      epu[k / 4][k % 4] = !m[k / 4 * 8 + 1][k % 4] && !m[k / 4 * 8 + 3][k % 4] && !fo;
      epd[k % 4] = k > 5 && fc(k) == 2'h2;
      epin[k / 4][k % 4] = eoe[k / 4][k % 4] ? eout[k / 4][k % 4] : (k > 3 ? drv_b[k % 4] : drv_a[k % 4]);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, a > 8'h3f ? 2'h2 : 2'h0);
    s_axi_bready <= 1'b0;
    if (a < 8'h40 && s[0]) m[a[5:2]] = d[3:0];
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output resp_t r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Pads, routing and every register, unmapped word included
  task automatic check_all();
    logic [31:0] d, e;
    resp_t r;
    int i, z;
    model_pins();
    chk("a_oe", port_a_pad_oe, eoe[0]);
    chk("b_oe", port_b_pad_oe, eoe[1]);
    chk("a_out", port_a_pad_out & eoe[0], eout[0] & eoe[0]);
    chk("b_out", port_b_pad_out & eoe[1], eout[1] & eoe[1]);
    chk("a_pu", port_a_pull_up_en, epu[0]);
    chk("b_pu", port_b_pull_up_en, epu[1]);
    chk("b_pd", port_b_pull_down_en, epd);
    chk("wake", {port_a_wake_en, port_b_wake_en}, {~m[4], ~m[12]});
    chk("drive", {port_a_drive_strong, port_b_drive_strong}, {m[7], m[15]});
    chk("analog", {analog_channel_zero, analog_channel_one, analog_channel_two, analog_channel_six,
      analog_channel_seven, reference_in_sel}, {fc(0) == 1, fc(1) == 1, fc(2) == 1, fc(6) == 1,
      fc(7) == 1, fc(1) == 3});
    z = fc(0) == 2 ? epin[0][0] : fc(2) == 2 && epin[0][2];
    chk("irq", {external_irq_zero, event_count_in_zero, external_irq_one, event_count_in_one},
      {z[0], z[0], {2{fc(1) == 2 && epin[0][1]}}});
    for (i = 0; i < 17; i++) begin
      rd(i * 4, d, r);
      e = i inside {3, 5, 6, 11, 13, 14} ? m[i] : 0;
      if (i == 0 || i == 8) e = (m[i + 3] & m[i]) | (~m[i + 3] & epin[i / 8]);
      chk("rdata", d, e);
      chk("rresp", r, i == 16 ? 2'h2 : 2'h0);
    end
  endtask
  task automatic do_reset();
    int i;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 16; i++) m[i] = i % 8 inside {0, 1, 2, 4} ? 4'hf : 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  // Random writes, pin levels and timer outputs, then a full compare
  initial begin
    aclk = 1'b0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = 62'h0;
    {drv_a, drv_b, timer_out_first, timer_out_second, pulse_out_zero, pulse_out_one} = 12'h0;
    void'($urandom(61));
    do_reset();
    check_all();
    repeat (200) begin
      drv_a <= 4'($urandom);
      drv_b <= 4'($urandom);
      {timer_out_first, timer_out_second, pulse_out_zero, pulse_out_one} <= 4'($urandom);
      wr(8'(($urandom % 17) * 4), $urandom, 4'($urandom));
      repeat (3) @(posedge aclk);
      check_all();
    end
    // Reset again from a busy state
    do_reset();
    check_all();
    wrap_up();
  end
  // Hang guard well beyond the expected run
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
endmodule
